// [bench/analog_front_model.sv]
// behavioural analog front end: eight inputs and the comparator
`timescale 1ns/10ps
`default_nettype none
module analog_front_model (
	input  wire logic       clock,
	input  wire logic [9:0] baseLevel,
	input  wire logic       res10,
	input  wire logic [2:0] anaChannel,
	input  wire logic [9:0] dacCode,
	input  wire logic       vrefConnect,
	output var  logic       compIn
);
	logic [9:0] level;
	logic       noise_ff;

	// channels a fixed step apart so a routing slip changes the code
	assign level = baseLevel + 10'(anaChannel) * 10'h05b;

	// detached ladder gives no reference, so the answer is noise
	initial noise_ff = 1'b0;
	always @(posedge clock) begin
		noise_ff <= ~noise_ff;
	end

	// keep bit when the input is at or above the trial code
	always_comb begin
		if (!vrefConnect) begin
			compIn = noise_ff;
		end else if (res10) begin
			compIn = (level >= dacCode);
		end else begin
			compIn = (level[9:2] >= dacCode[7:0]);
		end
	end
endmodule
`default_nettype wire

// [bench/sar_adc_sequencer_tb.sv]
// self-checking bench for the converter sequencer
`timescale 1ns/10ps
`default_nettype none
module sar_adc_sequencer_tb import sar_adc_pkg::*; ();
	logic        clock;
	logic        rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        extTrig;
	logic        compIn;
	logic [2:0]  anaChannel;
	logic [9:0]  dacCode;
	logic        sampleHold;
	logic        vrefConnect;
	logic        convIrq;
	logic        convActive;
	logic        ceOn;
	logic [9:0]  baseLevel;
	logic        res10Sel;
	logic [31:0] rd;
	logic        er;
	int          err_count = 0;
	int          compares = 0;
	int          cycles = 0;
	int          actCnt = 0;
	int          irqCnt = 0;

	sar_adc_sequencer dut (
		.clock(clock), .rst(rst), .ce(ceOn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .externalTriggerInput(extTrig),
		.compIn(compIn), .anaChannel(anaChannel), .dacCode(dacCode),
		.sampleHold(sampleHold), .vrefConnect(vrefConnect), .convIrq(convIrq),
		.convActive(convActive)
	);

	analog_front_model front (
		.clock(clock), .baseLevel(baseLevel), .res10(res10Sel),
		.anaChannel(anaChannel), .dacCode(dacCode), .vrefConnect(vrefConnect),
		.compIn(compIn)
	);

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	// activity counters; snapshots avoid racing the counting process
	always @(posedge clock) begin
		cycles++;
		if (convActive === 1'b1) actCnt++;
		if (convIrq === 1'b1) irqCnt++;
		if (cycles > 20000) begin
			err_count++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		if (err_count == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chkRange(input int got, input int lo, input int hi);
		compares++;
		if (got < lo || got > hi) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask

	// one apb transfer, held until pready; an idle cycle follows
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		chk({31'h0, pready}, 32'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
		chk({31'h0, pready}, 32'h0);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	// bounded wait on the running level
	task automatic waitAct(input logic v);
		int n;
		n = 0;
		while (convActive !== v && n < 3000) begin
			@(posedge clock);
			n++;
		end
		chk({31'h0, convActive}, {31'h0, v});
	endtask

	function automatic logic [31:0] expRes(input int ch, input logic r10);
		logic [9:0] lv;
		lv = baseLevel + 10'(ch) * 10'h05b;
		return r10 ? {22'h0, lv} : {24'h0, lv[9:2]};
	endfunction

	// reference always on first, reserved bit kept clear
	task automatic cfg(input logic r10, input logic d4, input logic sh);
		res10Sel <= r10;
		wr(OFF_CTRL1, {26'h0, 1'b1, 1'b0, r10, d4, 2'b00});
		wr(OFF_CTRL2, {31'h0, sh});
	endtask

	task automatic regsAfterReset();
		logic [7:0] addrs [5] = '{OFF_CTRL0, OFF_CTRL1, OFF_CTRL2, OFF_STATUS, OFF_RES_BASE};
		foreach (addrs[k]) begin
			rdc(addrs[k], 32'h0);
		end
		chk({31'h0, vrefConnect}, 32'h0);
		rdc(8'h40, 32'h0);
		chk({31'h0, er}, 32'h1);
		wr(8'h44, 32'h5a);
		chk({31'h0, er}, 32'h1);
		wr(OFF_CTRL1, 32'h20);
		repeat (2) @(posedge clock);
		chk({31'h0, vrefConnect}, 32'h1);
		wr(OFF_CTRL1, 32'h0);
		repeat (2) @(posedge clock);
		chk({31'h0, vrefConnect}, 32'h0);
	endtask

	// every resolution, divider and hold setting, one per channel
	task automatic oneShot(input int i);
		int cyc;
		int div;
		int a0;
		int q0;
		cyc = i[2] ? (i[0] ? 33 : 28) : (i[0] ? 59 : 49);
		div = i[1] ? 4 : 2;
		cfg(i[0], i[1], i[2]);
		a0 = actCnt;
		q0 = irqCnt;
		wr(OFF_CTRL0, {25'h0, 3'(i), 4'h1});
		waitAct(1'b1);
		chk({29'h0, anaChannel}, 32'(i));
		chk({31'h0, sampleHold}, {31'h0, i[2]});
		waitAct(1'b0);
		repeat (3) @(posedge clock);
		chkRange(actCnt - a0, cyc * div - div, cyc * div + div);
		chk(32'(irqCnt - q0), 32'h1);
		rdc(OFF_RES_BASE + 8'(4 * i), expRes(i, i[0]));
		rdc(OFF_STATUS, {25'h0, 3'(i), 4'h0});
	endtask

	// second start mid-run is harmless; a stop stores nothing
	task automatic midWrites();
		int a0;
		int q0;
		logic [31:0] keep;
		cfg(1'b1, 1'b0, 1'b0);
		baseLevel <= 10'h0c4;
		a0 = actCnt;
		wr(OFF_CTRL0, 32'h11);
		repeat (30) @(posedge clock);
		// frozen clock enable stretches the run by exactly the frozen cycles
		ceOn <= 1'b0;
		repeat (20) @(posedge clock);
		ceOn <= 1'b1;
		wr(OFF_CTRL0, 32'h11);
		waitAct(1'b0);
		chkRange(actCnt - a0, 59 * 2 + 18, 59 * 2 + 22);
		keep = expRes(1, 1'b1);
		rdc(OFF_RES_BASE + 8'h04, keep);
		baseLevel <= 10'h31e;
		q0 = irqCnt;
		wr(OFF_CTRL0, 32'h11);
		repeat (40) @(posedge clock);
		wr(OFF_CTRL0, 32'h10);
		repeat (4) @(posedge clock);
		chk({31'h0, convActive}, 32'h0);
		chk(32'(irqCnt - q0), 32'h0);
		rdc(OFF_RES_BASE + 8'h04, keep);
	endtask

	// continuous conversion, input moved while running
	task automatic repeatRun();
		int q0;
		cfg(1'b1, 1'b0, 1'b0);
		q0 = irqCnt;
		wr(OFF_CTRL0, 32'h23);
		repeat (400) @(posedge clock);
		rdc(OFF_RES_BASE + 8'h08, expRes(2, 1'b1));
		baseLevel <= baseLevel ^ 10'h155;
		repeat (300) @(posedge clock);
		rdc(OFF_RES_BASE + 8'h08, expRes(2, 1'b1));
		chk({31'h0, convActive}, 32'h1);
		chk(32'(irqCnt - q0), 32'h0);
		wr(OFF_CTRL0, 32'h22);
		repeat (4) @(posedge clock);
		chk({31'h0, convActive}, 32'h0);
	endtask

	// pin falls, then falls again mid-conversion to restart it
	task automatic extRun();
		int a0;
		int q0;
		cfg(1'b0, 1'b0, 1'b0);
		a0 = actCnt;
		q0 = irqCnt;
		wr(OFF_CTRL0, 32'h65);
		repeat (20) @(posedge clock);
		chk({31'h0, convActive}, 32'h0);
		extTrig <= 1'b0;
		waitAct(1'b1);
		chk({29'h0, anaChannel}, 32'h6);
		repeat (30) @(posedge clock);
		extTrig <= 1'b1;
		repeat (8) @(posedge clock);
		extTrig <= 1'b0;
		waitAct(1'b0);
		repeat (3) @(posedge clock);
		chkRange(actCnt - a0, 49 * 2 + 30, 49 * 2 + 70);
		chk(32'(irqCnt - q0), 32'h1);
		xfer(1'b0, OFF_STATUS, 32'h0);
		chk(rd & 32'h2, 32'h2);
		rdc(OFF_RES_BASE + 8'h18, expRes(6, 1'b0));
		wr(OFF_CTRL0, 32'h0);
		extTrig <= 1'b1;
	endtask

	initial begin
		rst = 1'b1;
		ceOn = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		extTrig = 1'b1;
		baseLevel = 10'h2a7;
		res10Sel = 1'b0;
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		regsAfterReset();
		for (int i = 0; i < 8; i++) begin
			oneShot(i);
		end
		midWrites();
		repeatRun();
		extRun();
		wrap_up();
	end
endmodule
`default_nettype wire

// [verilog/conv_clock_div.sv]
// conversion clock enable from the source clock, divide by two or four
`timescale 1ns/10ps
`default_nettype none
module conv_clock_div import sar_adc_pkg::*; (
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic ce,
	input  wire logic div4,
	output var  logic tick
);
	logic [1:0] cnt_ff;
	logic       tick_ff;
	logic [1:0] lastCnt;

	assign lastCnt = div4 ? DIV4_LAST : DIV2_LAST;

	// free running; a ratio change takes hold at once, on the count in progress
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt_ff  <= 2'h0;
			tick_ff <= 1'b0;
		end else if (ce) begin
			if (cnt_ff >= lastCnt) begin
				cnt_ff  <= 2'h0;
				tick_ff <= 1'b1;
			end else begin
				cnt_ff  <= cnt_ff + 2'h1;
				tick_ff <= 1'b0;
			end
		end
	end

	assign tick = tick_ff;
endmodule
`default_nettype wire

// [verilog/ext_trig_sync.sv]
// three-stage synchroniser with agreement filter for the trigger pin
`timescale 1ns/10ps
`default_nettype none
module ext_trig_sync import sar_adc_pkg::*; #(
	parameter logic IDLE_LVL = EXT_IDLE_LVL
) (
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic ce,
	input  wire logic pinIn,
	output var  logic level
);
	logic s1_ff;
	logic s2_ff;
	logic s3_ff;
	logic lvl_ff;

	// first stage feeds only the second
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s1_ff <= 1'b1;
			s2_ff <= 1'b1;
			s3_ff <= 1'b1;
		end else if (ce) begin
			s1_ff <= pinIn;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// a change counts once stages two and three agree
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			lvl_ff <= IDLE_LVL;
		end else if (ce && (s2_ff == s3_ff)) begin
			lvl_ff <= s2_ff;
		end
	end

	assign level = lvl_ff;
endmodule
`default_nettype wire

// [verilog/sar_adc_pkg.sv]
// constants, field layout and carrier types for the converter sequencer
package sar_adc_pkg;
	localparam logic [7:0] OFF_CTRL0     = 8'h00;
	localparam logic [7:0] OFF_CTRL1     = 8'h04;
	localparam logic [7:0] OFF_CTRL2     = 8'h08;
	localparam logic [7:0] OFF_STATUS    = 8'h0c;
	localparam logic [7:0] OFF_RES_BASE  = 8'h10;
	localparam logic [7:0] OFF_RES_END   = 8'h30;
	// control 0 fields
	localparam int         POS_START     = 0;
	localparam int         POS_REPEAT    = 1;
	localparam int         POS_EXTSEL    = 2;
	localparam int         POS_CHAN      = 4;
	// control 1 fields
	localparam int         POS_DIV4      = 2;
	localparam int         POS_RES10     = 3;
	localparam int         POS_RSVD      = 4;
	localparam int         POS_VREF      = 5;
	// control 2 fields
	localparam int         POS_SHOLD     = 0;
	localparam int         RES_HI_POS    = 8;
	localparam logic [5:0] CYC_8_PLAIN   = 6'h31;
	localparam logic [5:0] CYC_10_PLAIN  = 6'h3b;
	localparam logic [5:0] CYC_8_SHOLD   = 6'h1c;
	localparam logic [5:0] CYC_10_SHOLD  = 6'h21;
	localparam logic [1:0] DIV2_LAST     = 2'h1;
	localparam logic [1:0] DIV4_LAST     = 2'h3;
	localparam logic [9:0] MSB_10        = 10'h200;
	localparam logic [9:0] MSB_8         = 10'h080;
	localparam logic       EXT_IDLE_LVL  = 1'b1;

	typedef struct packed {
		logic [2:0] channel;
		logic       extSel;
		logic       repeatMode;
	} mode_t;

	typedef struct packed {
		logic vrefOn;
		logic rsvd;
		logic res10;
		logic div4;
		logic sampleHold;
	} cfg_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN  = 2'b10
	} conv_state_t;
endpackage

// [verilog/sar_adc_sequencer.sv]
// successive-approximation converter sequencer with apb register file
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module sar_adc_sequencer import sar_adc_pkg::*; #(
	parameter int CHANNELS = 8
) (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic        externalTriggerInput,
	input  wire logic        compIn,
	output var  logic [2:0]  anaChannel,
	output var  logic [9:0]  dacCode,
	output var  logic        sampleHold,
	output var  logic        vrefConnect,
	output var  logic        convIrq,
	output var  logic        convActive
);
	mode_t       mode_ff;
	cfg_t        cfg_ff;
	conv_state_t state_ff;
	logic        startFlag_ff;
	logic        pready_ff;
	logic        pslverr_ff;
	logic [31:0] prdata_ff;
	logic [2:0]  convCh_ff;
	logic [5:0]  cnt_ff;
	logic [9:0]  code_ff;
	logic [9:0]  mask_ff;
	logic        irq_ff;
	logic        active_ff;
	logic        extPrev_ff;
	logic [9:0]  resultMem_ff [CHANNELS];
	logic        extLevel;
	logic        tick;
	logic        wrEn;
	logic        rdEn;
	logic        wrCtrl0;
	logic        wrBit;
	logic        extFall;
	logic        running;
	logic        convDone;
	logic        oneShotClr;
	logic        swStart;
	logic        extStart;
	logic        stopReq;
	logic        startConv;
	logic [5:0]  totalCyc;
	logic [5:0]  winStart;
	logic [9:0]  nxt_code;
	logic        resHit;
	logic [7:0]  resOff;
	logic [31:0] nxt_rdata;
	logic        nxt_err;

	ext_trig_sync u_sync (
		.clock (clock),
		.rst   (rst),
		.ce    (ce),
		.pinIn (externalTriggerInput),
		.level (extLevel)
	);

	conv_clock_div u_div (
		.clock (clock),
		.rst   (rst),
		.ce    (ce),
		.div4  (cfg_ff.div4),
		.tick  (tick)
	);

	// apb: one wait state, write lands at the edge that sees pready
	assign wrEn    = ce && psel && penable && pready_ff && pwrite;
	assign rdEn    = ce && psel && penable && !pready_ff;
	assign wrCtrl0 = wrEn && (paddr == OFF_CTRL0);
	assign wrBit   = pwdata[POS_START];
	assign resHit  = (paddr >= OFF_RES_BASE) && (paddr < OFF_RES_END);
	// index from the result base, the base itself is word zero
	assign resOff  = paddr - OFF_RES_BASE;

	// conversion length from resolution and sample-and-hold
	always_comb begin
		case ({cfg_ff.sampleHold, cfg_ff.res10})
			2'b00:   totalCyc = CYC_8_PLAIN;
			2'b01:   totalCyc = CYC_10_PLAIN;
			2'b10:   totalCyc = CYC_8_SHOLD;
			default: totalCyc = CYC_10_SHOLD;
		endcase
	end
	assign winStart = cfg_ff.res10 ? (totalCyc - 6'h0b) : (totalCyc - 6'h09);

	// trigger and stop decisions
	assign running    = (state_ff == ST_RUN);
	assign extFall    = extPrev_ff && !extLevel;
	assign convDone   = ce && running && tick && (cnt_ff == totalCyc - 6'h01);
	assign oneShotClr = convDone && !mode_ff.repeatMode && !mode_ff.extSel;
	assign stopReq    = wrCtrl0 && !wrBit;
	// a one written while the flag is set is not a new start, unless the one-shot clear falls in that cycle
	assign swStart    = wrCtrl0 && wrBit && !pwdata[POS_EXTSEL]
		&& (!startFlag_ff || oneShotClr);
	assign extStart   = ce && extFall && mode_ff.extSel && startFlag_ff
		&& !stopReq;
	assign startConv  = swStart || extStart;

	// successive approximation step on each conversion clock
	always_comb begin
		nxt_code = code_ff;
		if (cnt_ff == winStart) begin
			nxt_code = cfg_ff.res10 ? MSB_10 : MSB_8;
		end else if (cnt_ff > winStart) begin
			nxt_code = (compIn ? code_ff : (code_ff & ~mask_ff)) | (mask_ff >> 1);
		end
	end

	// control registers written by software
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mode_ff <= '0;
			cfg_ff  <= '0;
		end else if (wrEn) begin
			if (paddr == OFF_CTRL0) begin
				mode_ff.channel    <= pwdata[POS_CHAN +: 3];
				mode_ff.extSel     <= pwdata[POS_EXTSEL];
				mode_ff.repeatMode <= pwdata[POS_REPEAT];
			end
			if (paddr == OFF_CTRL1) begin
				cfg_ff.vrefOn <= pwdata[POS_VREF];
				cfg_ff.rsvd   <= pwdata[POS_RSVD];
				cfg_ff.res10  <= pwdata[POS_RES10];
				cfg_ff.div4   <= pwdata[POS_DIV4];
			end
			if (paddr == OFF_CTRL2) begin
				cfg_ff.sampleHold <= pwdata[POS_SHOLD];
			end
		end
	end

	// start flag: software write beats the one-shot self clear
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			startFlag_ff <= 1'b0;
		end else if (wrCtrl0) begin
			startFlag_ff <= wrBit;
		end else if (oneShotClr) begin
			startFlag_ff <= 1'b0;
		end
	end

	// sequencer state
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_ff <= ST_IDLE;
		end else if (ce) begin
			case (state_ff)
				ST_IDLE: begin
					if (startConv) begin
						state_ff <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (stopReq) begin
						state_ff <= ST_IDLE;
					end else if (convDone && !mode_ff.repeatMode && !startConv) begin
						state_ff <= ST_IDLE;
					end
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// cycle counter, trial code and bit mask
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt_ff    <= 6'h00;
			code_ff   <= 10'h000;
			mask_ff   <= 10'h000;
			convCh_ff <= 3'h0;
		end else if (ce) begin
			if (startConv || (convDone && mode_ff.repeatMode)) begin
				cnt_ff  <= 6'h00;
				code_ff <= 10'h000;
				mask_ff <= 10'h000;
				if (startConv) begin
					convCh_ff <= swStart ? pwdata[POS_CHAN +: 3] : mode_ff.channel;
				end
			end else if (running && tick) begin
				cnt_ff  <= cnt_ff + 6'h01;
				code_ff <= nxt_code;
				if (cnt_ff == winStart) begin
					mask_ff <= cfg_ff.res10 ? MSB_10 : MSB_8;
				end else if (cnt_ff > winStart) begin
					mask_ff <= mask_ff >> 1;
				end
			end
		end
	end

	// whole result word replaced in one edge, readers never see a mix
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < CHANNELS; i++) begin
				resultMem_ff[i] <= 10'h000;
			end
		end else if (convDone) begin
			resultMem_ff[convCh_ff] <= nxt_code;
		end
	end

	// interrupt pulse for every completion outside repeat mode, one-shot or external
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq_ff <= 1'b0;
		end else if (ce) begin
			irq_ff <= convDone && !mode_ff.repeatMode;
		end
	end

	// registered copies of pin-facing state
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			active_ff  <= 1'b0;
			extPrev_ff <= EXT_IDLE_LVL;
		end else if (ce) begin
			active_ff  <= running;
			extPrev_ff <= extLevel;
		end
	end

	// read mux
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		nxt_err   = 1'b0;
		if (resHit) begin
			// low byte even address, top bits in the odd byte
			nxt_rdata[7:0] = resultMem_ff[resOff[4:2]][7:0];
			nxt_rdata[RES_HI_POS +: 2] = resultMem_ff[resOff[4:2]][9:8];
		end else begin
			case (paddr)
				OFF_CTRL0: begin
					nxt_rdata[POS_START]     = startFlag_ff;
					nxt_rdata[POS_REPEAT]    = mode_ff.repeatMode;
					nxt_rdata[POS_EXTSEL]    = mode_ff.extSel;
					nxt_rdata[POS_CHAN +: 3] = mode_ff.channel;
				end
				OFF_CTRL1: begin
					nxt_rdata[POS_VREF]  = cfg_ff.vrefOn;
					nxt_rdata[POS_RSVD]  = cfg_ff.rsvd;
					nxt_rdata[POS_RES10] = cfg_ff.res10;
					nxt_rdata[POS_DIV4]  = cfg_ff.div4;
				end
				OFF_CTRL2: begin
					nxt_rdata[POS_SHOLD] = cfg_ff.sampleHold;
				end
				OFF_STATUS: begin
					nxt_rdata[0]   = running;
					nxt_rdata[1]   = startFlag_ff;
					nxt_rdata[6:4] = convCh_ff;
				end
				default: begin
					nxt_err = 1'b1; // unmapped: zero data, error
				end
			endcase
		end
	end

	// apb answer registers
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
		end else if (ce) begin
			pready_ff  <= psel && penable && !pready_ff;
			pslverr_ff <= rdEn && nxt_err;
			if (rdEn) begin
				prdata_ff <= pwrite ? 32'h0000_0000 : nxt_rdata;
			end
		end
	end

	assign prdata      = prdata_ff;
	assign pready      = pready_ff;
	assign pslverr     = pslverr_ff;
	assign anaChannel  = convCh_ff;
	assign dacCode     = code_ff;
	assign sampleHold  = cfg_ff.sampleHold;
	assign vrefConnect = cfg_ff.vrefOn;
	assign convIrq     = irq_ff;
	assign convActive  = active_ff;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	sequence swRise;
		swStart && !running;
	endsequence

	sequence runEntered;
		running && (cnt_ff == 6'h00);
	endsequence

	a_sw_start: assert property (swRise |=> runEntered)
		else $error("software start did not begin a conversion");

	a_ext_retrig: assert property (extStart |=> runEntered)
		else $error("external falling edge did not restart conversion");

	a_conv_length: assert property ((convDone && !cfg_ff.sampleHold)
		|-> (cnt_ff == (cfg_ff.res10 ? 6'h3a : 6'h30)))
		else $error("conversion length wrong without sample and hold");

	a_shold_length: assert property ((convDone && cfg_ff.sampleHold)
		|-> (cnt_ff == (cfg_ff.res10 ? 6'h20 : 6'h1b)))
		else $error("conversion length wrong with sample and hold");

	a_oneshot_clear: assert property ((oneShotClr && !wrCtrl0)
		|=> !startFlag_ff && !running)
		else $error("one-shot did not clear flag and stop");

	a_irq_oneshot: assert property ((convDone && !mode_ff.repeatMode)
		|=> convIrq ##1 !convIrq)
		else $error("one-shot completion missed its interrupt pulse");

	a_repeat_quiet: assert property ((convDone && mode_ff.repeatMode && !stopReq)
		|=> !convIrq && running && (cnt_ff == 6'h00))
		else $error("repeat mode raised interrupt or failed to continue");

	a_stop_write: assert property ((stopReq && ce) |=> !running && !startFlag_ff)
		else $error("zero written to start flag did not stop");

	a_result_store: assert property (convDone
		|=> resultMem_ff[$past(convCh_ff)] == $past(nxt_code))
		else $error("result not stored in converted channel register");

	a_byte_8bit: assert property ((convDone && !cfg_ff.res10)
		|=> (resultMem_ff[$past(convCh_ff)][9:8] == 2'b00))
		else $error("eight-bit result spilled into the odd byte");

	// a ratio switch back to two may shorten the gap once
	a_div_four: assert property ((tick && ce && cfg_ff.div4)
		|=> (!tick || !cfg_ff.div4) [*3])
		else $error("divide-by-four spacing broken");

	a_vref_off: assert property ((wrEn && (paddr == OFF_CTRL1) && !pwdata[POS_VREF])
		|=> !vrefConnect)
		else $error("reference ladder not disconnected");
endmodule
`default_nettype wire
